// ==== sdpre_pkg.sv ====
// Shared constants and types for the DRAM power and refresh error block
package sdpre_pkg;
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;
  localparam int         NREG          = 7;
  localparam int         IDX_SELFREF   = 0;
  localparam int         IDX_LOWPOWER  = 1;
  localparam int         IDX_IRQ_SET   = 2;
  localparam int         IDX_IRQ_CLR   = 3;
  localparam int         IDX_IRQ_MASK  = 4;
  localparam int         IDX_IRQ_STAT  = 5;
  localparam int         IDX_TIMING    = 6;
  localparam logic [7:0] OFF_SELFREF   = 8'h00;
  localparam logic [7:0] OFF_LOWPOWER  = 8'h04;
  localparam logic [7:0] OFF_IRQ_SET   = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFF_TIMING    = 8'h18;
  localparam logic [7:0] REG_OFF [NREG] = '{OFF_SELFREF, OFF_LOWPOWER, OFF_IRQ_SET, OFF_IRQ_CLR,
                                            OFF_IRQ_MASK, OFF_IRQ_STAT, OFF_TIMING};
  localparam int         CMD_BIT_POS   = 0;
  localparam int         RFE_BIT_POS   = 0;
  localparam int         DLY_LSB       = 0;
  localparam int         DLY_W         = 4;
  localparam logic [3:0] DLY_RESET     = 4'h5;
  localparam logic       LP_RESET      = 1'b0;
  localparam logic       MASK_RESET    = 1'b0;
  localparam int         BURST_LEN_DEF = 4;
  localparam int         CNT_W         = 5;

  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_ACT   = 3'h1,
    CMD_RW    = 3'h2,
    CMD_REF   = 3'h3,
    CMD_SELF  = 3'h4,
    CMD_PDN   = 3'h5
  } sdpre_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_BURST  = 5'h02,
    ST_SELF   = 5'h04,
    ST_PDN    = 5'h08,
    ST_EXIT   = 5'h10
  } sdpre_state_t;
endpackage

// ==== sdpre_sync_edge.sv ====
// Two-flop synchroniser with edge detection for the memory link clock
`timescale 1ns/1ps
module sdpre_sync_edge (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule

// ==== sdpre_apb.sv ====
// APB address decode and strobes for the register file
`timescale 1ns/1ps
module sdpre_apb (
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [sdpre_pkg::ADDR_W-1:0] paddr,
  output logic [sdpre_pkg::NREG-1:0]     wr_stb,
  output logic [sdpre_pkg::NREG-1:0]     rd_setup,
  output logic [sdpre_pkg::NREG-1:0]     rd_done,
  output logic                           pready,
  output logic                           pslverr
);
  function automatic logic [sdpre_pkg::NREG-1:0] reg_dec(input logic [sdpre_pkg::ADDR_W-1:0] a);
    logic [sdpre_pkg::NREG-1:0] hit;
    hit = '0;
    for (int i = 0; i < sdpre_pkg::NREG; i++) begin
      hit[i] = (a == sdpre_pkg::REG_OFF[i]);
    end
    return hit;
  endfunction

  wire logic [sdpre_pkg::NREG-1:0] sel_vec = reg_dec(paddr);
  wire logic                       setup   = psel & ~penable;
  wire logic                       access  = psel & penable;

  assign wr_stb   = (access & pwrite) ? sel_vec : '0;
  assign rd_setup = (setup & ~pwrite) ? sel_vec : '0;
  assign rd_done  = (access & ~pwrite) ? sel_vec : '0;
  assign pready   = 1'b1;
  assign pslverr  = access & ~(|sel_vec);
endmodule

// ==== sdpre_ctrl.sv ====
// Power-saving, exit delay and refresh error control of the DRAM controller
`timescale 1ns/1ps
module sdpre_ctrl #(
  parameter int BURST_LEN = sdpre_pkg::BURST_LEN_DEF
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [sdpre_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sdpre_pkg::DATA_W-1:0] pwdata,
  output logic      [sdpre_pkg::DATA_W-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         link_clk,
  input  wire logic                         acc_req,
  output logic                              acc_ack,
  output logic                              acc_done,
  input  wire logic                         refresh_req,
  output logic                              memory_clock_out,
  output logic                              memory_clock_enable_pin,
  output sdpre_pkg::sdpre_cmd_t             mem_cmd,
  output logic                              irq
);
  localparam logic [sdpre_pkg::CNT_W-1:0] BURST_LOAD = sdpre_pkg::CNT_W'(BURST_LEN);

  logic [sdpre_pkg::NREG-1:0] wr_stb;
  logic [sdpre_pkg::NREG-1:0] rd_setup;
  logic [sdpre_pkg::NREG-1:0] rd_done;
  logic                       link_lvl;
  logic                       link_rise;
  logic                       link_fall;

  sdpre_apb u_apb (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .wr_stb   (wr_stb),
    .rd_setup (rd_setup),
    .rd_done  (rd_done),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  sdpre_sync_edge u_link (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (link_clk),
    .level    (link_lvl),
    .rise     (link_rise),
    .fall     (link_fall)
  );

  sdpre_pkg::sdpre_state_t     state;
  sdpre_pkg::sdpre_state_t     next_state;
  sdpre_pkg::sdpre_cmd_t       next_cmd;
  logic [sdpre_pkg::CNT_W-1:0] cnt;
  logic [sdpre_pkg::CNT_W-1:0] next_cnt;
  logic                        next_cke;
  logic                        cke;
  logic                        lowpower;
  logic                        mask;
  logic                        flag;
  logic                        flag_snap;
  logic [sdpre_pkg::DLY_W-1:0] exit_selfrefresh_delay;
  logic                        selfref_pend;
  logic                        ref_pend;
  logic                        ack_c;
  logic                        done_c;
  logic                        issue_self_c;
  logic                        issue_ref_c;

  wire logic edge_evt = link_rise | link_fall;
  wire logic st_exit  = (state == sdpre_pkg::ST_EXIT);
  wire logic adv      = link_fall | (st_exit & edge_evt);
  wire logic [sdpre_pkg::CNT_W-1:0] exit_load =
    sdpre_pkg::CNT_W'({exit_selfrefresh_delay, 1'b1});
  wire logic ref_issue_now = adv & issue_ref_c;
  wire logic self_issue_now = adv & issue_self_c;
  wire logic ref_err_evt = refresh_req & ref_pend & ~ref_issue_now;
  wire logic stat_clear = rd_done[sdpre_pkg::IDX_IRQ_STAT] & flag_snap;
  wire logic cmd_bit_w = pwdata[sdpre_pkg::CMD_BIT_POS];
  wire logic rfe_bit_w = pwdata[sdpre_pkg::RFE_BIT_POS];

  // Sequencer: commands change on falling link edges, except in exit, which counts both edges and ends on a rising one
  always_comb begin
    next_state   = state;
    next_cmd     = sdpre_pkg::CMD_NOP;
    next_cnt     = cnt;
    next_cke     = cke;
    ack_c        = 1'b0;
    done_c       = 1'b0;
    issue_self_c = 1'b0;
    issue_ref_c  = 1'b0;
    case (state)
      sdpre_pkg::ST_IDLE: begin
        if (selfref_pend) begin
          next_cmd     = sdpre_pkg::CMD_SELF;
          next_cke     = 1'b0;
          next_state   = sdpre_pkg::ST_SELF;
          issue_self_c = 1'b1;
        end else if (ref_pend) begin
          next_cmd    = sdpre_pkg::CMD_REF;
          issue_ref_c = 1'b1;
        end else if (acc_req) begin
          next_cmd   = sdpre_pkg::CMD_ACT;
          next_cnt   = BURST_LOAD;
          next_state = sdpre_pkg::ST_BURST;
          ack_c      = 1'b1;
        end
      end
      sdpre_pkg::ST_BURST: begin
        if (cnt != '0) begin
          next_cmd = sdpre_pkg::CMD_RW;
          next_cnt = cnt - 1'b1;
        end else begin
          done_c = 1'b1;
          if (lowpower) begin
            next_cmd   = sdpre_pkg::CMD_PDN;
            next_cke   = 1'b0;
            next_state = sdpre_pkg::ST_PDN;
          end else begin
            next_state = sdpre_pkg::ST_IDLE;
          end
        end
      end
      sdpre_pkg::ST_SELF: begin
        if (acc_req) begin
          next_cke   = 1'b1;
          next_cnt   = exit_load;
          next_state = sdpre_pkg::ST_EXIT;
        end
      end
      sdpre_pkg::ST_PDN: begin
        if (acc_req | ref_pend) begin
          next_cke   = 1'b1;
          next_cnt   = exit_load;
          next_state = sdpre_pkg::ST_EXIT;
        end
      end
      sdpre_pkg::ST_EXIT: begin
        if (cnt > 5'h01) begin
          next_cnt = cnt - 1'b1;
        end else if (acc_req) begin
          next_cmd   = sdpre_pkg::CMD_ACT;
          next_cnt   = BURST_LOAD;
          next_state = sdpre_pkg::ST_BURST;
          ack_c      = 1'b1;
        end else begin
          next_state = sdpre_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sdpre_pkg::ST_IDLE;
        next_cke   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state   <= sdpre_pkg::ST_IDLE;
      mem_cmd <= sdpre_pkg::CMD_NOP;
      cnt     <= '0;
      cke     <= 1'b1;
    end else if (adv) begin
      state   <= next_state;
      mem_cmd <= next_cmd;
      cnt     <= next_cnt;
      cke     <= next_cke;
    end
  end

  // Memory clock held low while in self-refresh
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memory_clock_out <= 1'b0;
    end else begin
      memory_clock_out <= link_lvl & (state != sdpre_pkg::ST_SELF);
    end
  end

  assign memory_clock_enable_pin = cke;
  assign acc_ack                 = adv & ack_c;
  assign acc_done                = adv & done_c;

  // Pending requests; a new request wins over its own issue
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      selfref_pend <= 1'b0;
      ref_pend     <= 1'b0;
    end else begin
      if (wr_stb[sdpre_pkg::IDX_SELFREF] && cmd_bit_w) begin
        selfref_pend <= 1'b1;
      end else if (self_issue_now) begin
        selfref_pend <= 1'b0;
      end
      if (refresh_req && state != sdpre_pkg::ST_SELF) begin
        ref_pend <= 1'b1;
      end else if (ref_issue_now) begin
        ref_pend <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lowpower               <= sdpre_pkg::LP_RESET;
      exit_selfrefresh_delay <= sdpre_pkg::DLY_RESET;
      mask                   <= sdpre_pkg::MASK_RESET;
    end else begin
      if (wr_stb[sdpre_pkg::IDX_LOWPOWER]) begin
        lowpower <= cmd_bit_w;
      end
      if (wr_stb[sdpre_pkg::IDX_TIMING]) begin
        exit_selfrefresh_delay <= pwdata[sdpre_pkg::DLY_LSB +: sdpre_pkg::DLY_W];
      end
      if (wr_stb[sdpre_pkg::IDX_IRQ_SET] && rfe_bit_w) begin
        mask <= 1'b1;
      end else if (wr_stb[sdpre_pkg::IDX_IRQ_CLR] && rfe_bit_w) begin
        mask <= 1'b0;
      end
    end
  end

  wire logic next_flag = (flag & ~stat_clear) | ref_err_evt;
  wire logic next_irq  = next_flag & mask;

  // Error flag: only the value actually returned is cleared, new events win
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag      <= 1'b0;
      flag_snap <= 1'b0;
      irq       <= 1'b0;
    end else begin
      flag <= (flag & ~stat_clear) | ref_err_evt;
      if (rd_setup[sdpre_pkg::IDX_IRQ_STAT]) begin
        flag_snap <= flag;
      end
      irq <= next_irq;
    end
  end

  // Read data captured in the setup phase
  wire logic [sdpre_pkg::DATA_W-1:0] rd_mux =
      rd_setup[sdpre_pkg::IDX_LOWPOWER] ? sdpre_pkg::DATA_W'(lowpower) :
      rd_setup[sdpre_pkg::IDX_IRQ_MASK] ? sdpre_pkg::DATA_W'(mask) :
      rd_setup[sdpre_pkg::IDX_IRQ_STAT] ? sdpre_pkg::DATA_W'(flag) :
      rd_setup[sdpre_pkg::IDX_TIMING]   ? sdpre_pkg::DATA_W'(exit_selfrefresh_delay) :
      '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // Checks
  logic [sdpre_pkg::CNT_W-1:0] exit_edges;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !st_exit) begin
      exit_edges <= '0;
    end else if (edge_evt) begin
      exit_edges <= exit_edges + 1'b1;
    end
  end

  wire logic exit_end = st_exit & edge_evt & (next_state != sdpre_pkg::ST_EXIT);

  property p_exit_len;
    @(posedge clk_sys) disable iff (!rst_n)
      exit_end |-> (exit_edges + 1'b1 == exit_load);
  endproperty
  a_exit_len: assert property (p_exit_len) else $error("exit delay length wrong");

  property p_exit_half;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_exit && edge_evt && exit_selfrefresh_delay == '0 && exit_edges == '0)
        |-> next_state != sdpre_pkg::ST_EXIT;
  endproperty
  a_exit_half: assert property (p_exit_half) else $error("zero delay not half period");

  sequence s_self_entered;
    state == sdpre_pkg::ST_SELF;
  endsequence
  property p_self_pins;
    @(posedge clk_sys) disable iff (!rst_n)
      s_self_entered ##1 s_self_entered |-> !memory_clock_out && !memory_clock_enable_pin;
  endproperty
  a_self_pins: assert property (p_self_pins) else $error("self-refresh pins wrong");

  property p_self_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_stb[sdpre_pkg::IDX_SELFREF] && !cmd_bit_w && !selfref_pend) |=> !selfref_pend;
  endproperty
  a_self_zero: assert property (p_self_zero) else $error("zero write started self-refresh");

  property p_self_wake;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == sdpre_pkg::ST_SELF && acc_req && link_fall)
        |=> st_exit && memory_clock_enable_pin;
  endproperty
  a_self_wake: assert property (p_self_wake) else $error("no exit from self-refresh");

  property p_no_pdn;
    @(posedge clk_sys) disable iff (!rst_n)
      (!lowpower && !$past(lowpower)) |-> mem_cmd != sdpre_pkg::CMD_PDN;
  endproperty
  a_no_pdn: assert property (p_no_pdn) else $error("low-power command while disabled");

  property p_pdn_after;
    @(posedge clk_sys) disable iff (!rst_n)
      (acc_done && lowpower) |=> mem_cmd == sdpre_pkg::CMD_PDN && !memory_clock_enable_pin;
  endproperty
  a_pdn_after: assert property (p_pdn_after) else $error("no low-power after burst");

  property p_pdn_wake;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == sdpre_pkg::ST_PDN && acc_req && link_fall) |=> memory_clock_enable_pin;
  endproperty
  a_pdn_wake: assert property (p_pdn_wake) else $error("no wake from low-power");

  property p_mask_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_stb[sdpre_pkg::IDX_IRQ_SET] && rfe_bit_w) |=> mask;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set");

  property p_mask_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_stb[sdpre_pkg::IDX_IRQ_CLR] && rfe_bit_w && !wr_stb[sdpre_pkg::IDX_IRQ_SET]) |=> !mask;
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");

  property p_mask_read;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_setup[sdpre_pkg::IDX_IRQ_MASK] |=> prdata[sdpre_pkg::RFE_BIT_POS] == $past(mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_stat_rc;
    @(posedge clk_sys) disable iff (!rst_n)
      (rd_done[sdpre_pkg::IDX_IRQ_STAT] && flag_snap && !ref_err_evt) |=> !flag;
  endproperty
  a_stat_rc: assert property (p_stat_rc) else $error("status not cleared by read");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 irq == $past(flag & mask, 1) || irq == (flag & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_ref_err;
    @(posedge clk_sys) disable iff (!rst_n)
      (refresh_req && ref_pend && !ref_issue_now) |=> flag ##1 (flag || $past(stat_clear));
  endproperty
  a_ref_err: assert property (p_ref_err) else $error("refresh error lost");
endmodule

// ==== sdpre_sdram_model.sv ====
// Behavioural memory device that tallies the activate, refresh, power-down and self-refresh commands it receives
`timescale 1ns/1ps
module sdpre_sdram_model (
  input  wire logic                  clk_sys,
  input  wire logic                  memory_clock_out,
  input  wire logic                  memory_clock_enable_pin,
  input  wire sdpre_pkg::sdpre_cmd_t mem_cmd,
  output int                         act_cnt,
  output int                         ref_cnt,
  output int                         pdn_cnt,
  output int                         self_cnt,
  output int                         asleep_clk
);
  logic clk_q   = 1'b0;
  logic cke_q   = 1'b1;
  logic in_self = 1'b0;
  logic clk_up;

  assign clk_up = !clk_q && memory_clock_out;

  always @(posedge clk_sys) begin
    clk_q <= memory_clock_out;
    cke_q <= memory_clock_enable_pin;
    // Activate and refresh commands count only on a memory clock rise while enabled
    if (clk_up && memory_clock_enable_pin) begin
      if (mem_cmd == sdpre_pkg::CMD_ACT)
        act_cnt <= act_cnt + 1;
      if (mem_cmd == sdpre_pkg::CMD_REF)
        ref_cnt <= ref_cnt + 1;
    end
    if (cke_q && !memory_clock_enable_pin) begin
      if (mem_cmd == sdpre_pkg::CMD_SELF) begin
        self_cnt <= self_cnt + 1;
        in_self  <= 1'b1;
      end
      if (mem_cmd == sdpre_pkg::CMD_PDN)
        pdn_cnt <= pdn_cnt + 1;
    end
    if (memory_clock_enable_pin)
      in_self <= 1'b0;
    // A memory clock rise during self-refresh is a fault
    if (in_self && clk_up)
      asleep_clk <= asleep_clk + 1;
  end
endmodule

// ==== sdpre_ctrl_test.sv ====
// Self-checking testbench for the DRAM power and refresh error block
`timescale 1ns/1ps
module sdpre_ctrl_test;
  logic                  clk_sys     = 1'b0;
  logic                  rst_n       = 1'b0;
  logic                  psel        = 1'b0;
  logic                  penable     = 1'b0;
  logic                  pwrite      = 1'b0;
  logic [7:0]            paddr       = 8'h00;
  logic [31:0]           pwdata      = 32'h0;
  logic                  link_clk    = 1'b0;
  logic                  acc_req     = 1'b0;
  logic                  refresh_req = 1'b0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  acc_ack;
  logic                  acc_done;
  logic                  mclk;
  logic                  cke;
  logic                  irq;
  sdpre_pkg::sdpre_cmd_t mem_cmd;
  int                    act_cnt, ref_cnt, pdn_cnt, self_cnt, asleep_clk;
  int                    miscompares  = 0;
  int                    total_checks = 0;
  int                    d;
  int                    c0;
  int                    a0;
  logic [31:0]           rd;
  logic                  er;

  always #20 clk_sys = ~clk_sys;

  initial begin
    #37;
    forever #160 link_clk = ~link_clk;
  end

  sdpre_ctrl #(.BURST_LEN(2)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .acc_req(acc_req), .acc_ack(acc_ack), .acc_done(acc_done),
    .refresh_req(refresh_req), .memory_clock_out(mclk), .memory_clock_enable_pin(cke),
    .mem_cmd(mem_cmd), .irq(irq));

  sdpre_sdram_model mem (
    .clk_sys(clk_sys), .memory_clock_out(mclk), .memory_clock_enable_pin(cke),
    .mem_cmd(mem_cmd), .act_cnt(act_cnt), .ref_cnt(ref_cnt), .pdn_cnt(pdn_cnt),
    .self_cnt(self_cnt), .asleep_clk(asleep_clk));

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] dat);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1, "apb wait");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp, msg);
  endtask

  // Cycles with enable high until the activate acknowledge is seen
  task access;
    int n;
    n = 0;
    d = 0;
    @(posedge clk_sys);
    acc_req <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (cke === 1'b1)
        d++;
    end while (acc_ack !== 1'b1 && n < 400);
    acc_req <= 1'b0;
    while (acc_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 400), 32'h1, "access hang");
  endtask

  task pulse(input int k);
    @(posedge clk_sys);
    refresh_req <= 1'b1;
    repeat (k) @(posedge clk_sys);
    refresh_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task t_reset;
    chk(32'(cke), 32'h1, "enable after reset");
    rdchk(sdpre_pkg::OFF_LOWPOWER, 32'h0, "lowpower reset");
    rdchk(sdpre_pkg::OFF_TIMING, 32'h5, "delay reset");
    rdchk(sdpre_pkg::OFF_IRQ_MASK, 32'h0, "mask reset");
    rdchk(sdpre_pkg::OFF_IRQ_STAT, 32'h0, "status reset");
    rdchk(sdpre_pkg::OFF_SELFREF, 32'h0, "write-only read");
    rdchk(8'h1c, 32'h0, "unmapped read");
    chk(32'(er), 32'h1, "unmapped error");
  endtask

  task t_mask;
    apb(sdpre_pkg::OFF_IRQ_SET, 1'b1, 32'h0);
    rdchk(sdpre_pkg::OFF_IRQ_MASK, 32'h0, "set zero");
    apb(sdpre_pkg::OFF_IRQ_SET, 1'b1, 32'h1);
    rdchk(sdpre_pkg::OFF_IRQ_MASK, 32'h1, "set one");
    apb(sdpre_pkg::OFF_IRQ_CLR, 1'b1, 32'h0);
    rdchk(sdpre_pkg::OFF_IRQ_MASK, 32'h1, "clear zero");
    apb(sdpre_pkg::OFF_IRQ_CLR, 1'b1, 32'h1);
    rdchk(sdpre_pkg::OFF_IRQ_MASK, 32'h0, "clear one");
  endtask

  task t_refresh;
    c0 = ref_cnt;
    pulse(1);
    repeat (30) @(posedge clk_sys);
    chk(32'(ref_cnt), 32'(c0 + 1), "refresh issued");
    rdchk(sdpre_pkg::OFF_IRQ_STAT, 32'h0, "lone request");
    apb(sdpre_pkg::OFF_IRQ_SET, 1'b1, 32'h1);
    pulse(3);
    chk(32'(irq), 32'h1, "irq on");
    rdchk(sdpre_pkg::OFF_IRQ_STAT, 32'h1, "overrun seen");
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h0, "irq off");
    rdchk(sdpre_pkg::OFF_IRQ_STAT, 32'h0, "read clears");
    repeat (30) @(posedge clk_sys);
    apb(sdpre_pkg::OFF_IRQ_CLR, 1'b1, 32'h1);
    pulse(3);
    chk(32'(irq), 32'h0, "masked irq");
    rdchk(sdpre_pkg::OFF_IRQ_STAT, 32'h1, "masked flag");
  endtask

  task t_lowpower;
    c0 = pdn_cnt;
    access();
    repeat (16) @(posedge clk_sys);
    chk(32'(cke), 32'h1, "awake without lowpower");
    apb(sdpre_pkg::OFF_LOWPOWER, 1'b1, 32'h1);
    rdchk(sdpre_pkg::OFF_LOWPOWER, 32'h1, "lowpower set");
    access();
    repeat (16) @(posedge clk_sys);
    chk(32'(cke), 32'h0, "sleep after burst");
    chk(32'(pdn_cnt), 32'(c0 + 1), "lowpower command");
    a0 = act_cnt;
    access();
    chk(32'(act_cnt), 32'(a0 + 1), "woken for access");
    repeat (16) @(posedge clk_sys);
    chk(32'(cke), 32'h0, "sleep again");
    chk(32'(pdn_cnt), 32'(c0 + 2), "second lowpower");
    apb(sdpre_pkg::OFF_LOWPOWER, 1'b1, 32'h0);
    access();
    repeat (16) @(posedge clk_sys);
    chk(32'(cke), 32'h1, "no sleep when off");
    chk(32'(pdn_cnt), 32'(c0 + 2), "no lowpower command");
  endtask

  task t_selfref(input int n);
    apb(sdpre_pkg::OFF_TIMING, 1'b1, 32'(n));
    c0 = self_cnt;
    apb(sdpre_pkg::OFF_SELFREF, 1'b1, 32'h0);
    repeat (24) @(posedge clk_sys);
    chk(32'(cke), 32'h1, "zero write ignored");
    apb(sdpre_pkg::OFF_SELFREF, 1'b1, 32'h1);
    repeat (24) @(posedge clk_sys);
    chk(32'(cke), 32'h0, "enable low");
    chk(32'(self_cnt), 32'(c0 + 1), "self-refresh command");
    chk(32'(mclk), 32'h0, "clock held");
    chk(32'(asleep_clk), 32'h0, "clock stopped");
    c0 = act_cnt;
    access();
    chk(32'(d >= 8 * n + 4 && d <= 8 * n + 6), 32'h1, "exit delay");
    chk(32'(act_cnt), 32'(c0 + 1), "activate after exit");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_refresh();
    t_lowpower();
    t_selfref(5);
    t_selfref(0);
    t_selfref(15);
    end_sim();
  end

  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
endmodule
